// File: rtl/ndc_dev.sv
// NAND target end: command sequence decoder with per-LUN busy model
`include "ndc_map.svh"
module ndc_dev import ndc_pkg::*; #(
	parameter int LUNS = 2,
	parameter int LW = $clog2(LUNS),
	parameter logic [15:0] T_ARR =
		16'((`NDC_T_ARRAY_NS + `NDC_CLK_NS - 1) / `NDC_CLK_NS),
	parameter logic [15:0] T_CACHE =
		16'((`NDC_T_CACHE_NS + `NDC_CLK_NS - 1) / `NDC_CLK_NS),
	parameter logic [15:0] T_RST =
		16'((`NDC_T_RST_NS + `NDC_CLK_NS - 1) / `NDC_CLK_NS)
) (
	input wire logic clk_i, // System clock
	input wire logic nrst_i, // Async reset, active low
	ndc_link_if.device lnk, // Link to host
	input wire logic [7:0] id_byte_i, // Next ID/feature byte
	output logic id_rd_o, // Pulse: id_byte_i taken
	output logic op_valid_o, // Pulse: array op started
	output ndc_op_e op_kind_o, // Kind of started op
	output logic [LW-1:0] op_lun_o, // LUN of started op
	output logic [23:0] op_row_o, // Last three address bytes
	output logic op_reject_o, // Pulse: sequence ignored
	output logic data_valid_o, // Pulse: data byte written
	output logic [7:0] data_o, // Written data byte
	output logic [LUNS-1:0] lun_rdy_o, // Per-LUN ready
	output logic [LUNS-1:0] lun_array_ready_bit_o // Per-LUN array ready
);
	// ************************************
	// Pin synchronisers
	// ************************************
	logic [12:0] s1_ff, s2_ff, s3_ff, lvl_ff;
	wire [12:0] pins = {lnk.lclk, lnk.ce_n, lnk.cle, lnk.ale, lnk.wen,
		lnk.dq};
	// Level changes only once stages two and three agree
	wire [12:0] nxt_lvl = (s2_ff & s3_ff) | (lvl_ff & (s2_ff ^ s3_ff));
	wire rise = nxt_lvl[12] & ~lvl_ff[12];
	wire fall = ~nxt_lvl[12] & lvl_ff[12];
	wire sel = ~nxt_lvl[11];
	wire p_cle = nxt_lvl[10];
	wire p_ale = nxt_lvl[9];
	wire p_wen = nxt_lvl[8];
	wire [7:0] b = nxt_lvl[7:0];
	wire cmd_cyc = rise & sel & p_cle & ~p_ale & p_wen;
	wire addr_cyc = rise & sel & ~p_cle & p_ale & p_wen;
	wire data_cyc = rise & sel & ~p_cle & ~p_ale & p_wen;
	wire rd_pat = sel & p_cle & p_ale & ~p_wen;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_ff <= 13'h0800;
			s2_ff <= 13'h0800;
			s3_ff <= 13'h0800;
			lvl_ff <= 13'h0800;
		end else begin
			s1_ff <= pins;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			lvl_ff <= nxt_lvl;
		end
	end

	// ************************************
	// Sequence decode
	// ************************************
	ndc_st_e st_ff, c_after, c_after_ff;
	ndc_op_e c_kind;
	logic [2:0] cnt_ff, c_need;
	logic [7:0] cmd1_ff;
	logic [23:0] row_ff;
	logic two_ff, rdmode_ff, c_fire, c_bad, c_two, c_rd;
	logic [LW-1:0] last_lun_ff;
	wire [LUNS-1:0] rdy;
	wire [LUNS-1:0] array_ready_bit;
	ndc_cls_e prev [LUNS];
	wire wr_ok = data_cyc & ((st_ff == ST_DATA) | (st_ff == ST_FEAT));

	always_comb begin
		c_kind = OP_NONE;
		c_fire = 1'b0;
		c_bad = 1'b0;
		c_need = 3'h0;
		c_after = ST_IDLE;
		c_two = 1'b0;
		c_rd = 1'b0;
		case (st_ff)
			ST_RCONF: begin
				c_fire = 1'b1;
				case (b)
					`NDC_CMD_RD_CONF: c_kind = OP_RD_PAGE;
					`NDC_CMD_RD_MP: c_kind = OP_RD_MP;
					`NDC_CMD_RD_CACHE: c_kind = OP_RD_CACHE_RND;
					`NDC_CMD_CB_RD: c_kind = OP_CB_READ;
					default: begin
						c_fire = 1'b0;
						c_bad = 1'b1;
					end
				endcase
			end
			ST_DATA: begin
				c_fire = 1'b1;
				case (b)
					`NDC_CMD_PG_CONF: c_kind = (cmd1_ff == `NDC_CMD_CB_PROG) ?
						OP_CB_PROG : OP_PROG;
					`NDC_CMD_PG_MP: c_kind = (cmd1_ff == `NDC_CMD_CB_PROG) ?
						OP_CB_PROG_MP : OP_PROG_MP;
					`NDC_CMD_PG_CACHE: c_kind = OP_PROG_CACHE;
					`NDC_CMD_CB_PROG: begin
						// Row change keeps the program context open
						c_fire = 1'b0;
						c_need = `NDC_ADDR_PAGE;
						c_after = ST_DATA;
					end
					default: begin
						c_fire = 1'b0;
						c_bad = 1'b1;
					end
				endcase
			end
			ST_ECONF: begin
				c_fire = 1'b1;
				case (b)
					`NDC_CMD_ER_CONF: c_kind = two_ff ? OP_ERASE_2P : OP_ERASE;
					`NDC_CMD_ER_MP: c_kind = OP_ERASE_MP;
					`NDC_CMD_ERASE: begin
						c_fire = 1'b0;
						c_two = 1'b1;
						c_need = `NDC_ADDR_ROW;
						c_after = ST_ECONF;
					end
					default: begin
						c_fire = 1'b0;
						c_bad = 1'b1;
					end
				endcase
			end
			default: begin
				// An unfinished address or feature phase is abandoned
				case (b)
					`NDC_CMD_READ: begin
						c_need = `NDC_ADDR_PAGE;
						c_after = ST_RCONF;
					end
					`NDC_CMD_RD_CACHE: begin
						c_fire = 1'b1;
						c_kind = OP_RD_CACHE_SEQ;
					end
					`NDC_CMD_RD_END: begin
						c_fire = 1'b1;
						c_kind = OP_RD_CACHE_END;
					end
					`NDC_CMD_PROG, `NDC_CMD_PROG_ALT, `NDC_CMD_CB_PROG: begin
						c_need = `NDC_ADDR_PAGE;
						c_after = ST_DATA;
					end
					`NDC_CMD_ERASE: begin
						c_need = `NDC_ADDR_ROW;
						c_after = ST_ECONF;
					end
					`NDC_CMD_ID, `NDC_CMD_GET_FEAT: begin
						c_need = `NDC_ADDR_ONE;
						c_rd = 1'b1;
					end
					`NDC_CMD_SET_FEAT: begin
						c_need = `NDC_ADDR_ONE;
						c_after = ST_FEAT;
					end
					default: c_bad = 1'b1;
				endcase
			end
		endcase
	end

	// ************************************
	// Busy-state acceptance
	// ************************************
	wire is_rst = cmd_cyc & (b == `NDC_CMD_RESET);
	wire no_addr = (c_kind == OP_RD_CACHE_SEQ) | (c_kind == OP_RD_CACHE_END);
	wire [LW-1:0] f_lun = no_addr ? last_lun_ff : row_ff[`NDC_LUN_POS +: LW];
	wire cache_rd = no_addr | (c_kind == OP_RD_CACHE_RND) |
		(c_kind == OP_RD_MP);
	// Only the addressed LUN's state matters here
	wire ok = rdy[f_lun] & (array_ready_bit[f_lun] |
		(cache_rd & (prev[f_lun] == CLS_READ)) |
		((c_kind == OP_PROG_CACHE) & (prev[f_lun] == CLS_CPROG)));
	wire accept = cmd_cyc & ~is_rst & c_fire & ok;
	wire reject = cmd_cyc & ~is_rst & ((c_fire & ~ok) | c_bad);
	// Queued planes and cache ops free the LUN early
	wire quick = cache_rd | (c_kind == OP_PROG_CACHE) |
		(c_kind == OP_PROG_MP) | (c_kind == OP_ERASE_MP) |
		(c_kind == OP_CB_PROG_MP);
	ndc_cls_e new_cls;
	assign new_cls = (cache_rd | (c_kind == OP_RD_PAGE)) ? CLS_READ :
		(c_kind == OP_PROG_CACHE) ? CLS_CPROG : CLS_OTHER;

	genvar g;
	generate
		for (g = 0; g < LUNS; g++) begin : g_lun
			logic [15:0] rcnt_ff, acnt_ff;
			ndc_cls_e prev_ff;
			wire start = accept & (f_lun == LW'(g));
			always_ff @(posedge clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					rcnt_ff <= 16'h0000;
					acnt_ff <= 16'h0000;
					prev_ff <= CLS_OTHER;
				end else if (is_rst) begin
					rcnt_ff <= T_RST;
					acnt_ff <= T_RST;
					prev_ff <= CLS_OTHER;
				end else if (start) begin
					rcnt_ff <= quick ? T_CACHE : T_ARR;
					acnt_ff <= T_ARR;
					prev_ff <= new_cls;
				end else begin
					if (rcnt_ff != 16'h0000)
						rcnt_ff <= rcnt_ff - 16'h0001;
					if (acnt_ff != 16'h0000)
						acnt_ff <= acnt_ff - 16'h0001;
				end
			end
			assign rdy[g] = (rcnt_ff == 16'h0000);
			assign array_ready_bit[g] = rdy[g] & (acnt_ff == 16'h0000);
			assign prev[g] = prev_ff;
		end
	endgenerate
	assign lun_rdy_o = rdy;
	assign lun_array_ready_bit_o = array_ready_bit;
	assign lnk.rb_n = &rdy;

	// ************************************
	// Sequence state and outputs
	// ************************************
	logic [7:0] dq_ff;
	logic oe_ff, dqs_ff;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_ff <= ST_IDLE;
			c_after_ff <= ST_IDLE;
			cnt_ff <= 3'h0;
			cmd1_ff <= 8'h00;
			row_ff <= 24'h000000;
			two_ff <= 1'b0;
			rdmode_ff <= 1'b0;
			last_lun_ff <= '0;
			op_valid_o <= 1'b0;
			op_kind_o <= OP_NONE;
			op_lun_o <= '0;
			op_row_o <= 24'h000000;
			op_reject_o <= 1'b0;
			data_valid_o <= 1'b0;
			data_o <= 8'h00;
		end else begin
			op_valid_o <= accept | is_rst;
			op_reject_o <= reject;
			data_valid_o <= 1'b0;
			if (is_rst) begin
				st_ff <= ST_IDLE;
				rdmode_ff <= 1'b0;
				two_ff <= 1'b0;
				op_kind_o <= OP_RESET;
			end else if (cmd_cyc) begin
				rdmode_ff <= c_rd;
				if (c_need != 3'h0) begin
					st_ff <= ST_ADDR;
					cnt_ff <= c_need;
					c_after_ff <= c_after;
					two_ff <= c_two;
					if (st_ff != ST_DATA && st_ff != ST_ECONF)
						cmd1_ff <= b;
				end else
					st_ff <= ST_IDLE;
				if (accept) begin
					op_kind_o <= c_kind;
					op_lun_o <= f_lun;
					op_row_o <= row_ff;
					last_lun_ff <= f_lun;
				end
			end else if (addr_cyc && st_ff == ST_ADDR) begin
				row_ff <= {row_ff[15:0], b};
				cnt_ff <= cnt_ff - 3'h1;
				if (cnt_ff == 3'h1) begin
					st_ff <= c_after_ff;
					cnt_ff <= `NDC_FEAT_BYTES;
				end
			end else if (wr_ok) begin
				data_valid_o <= 1'b1;
				data_o <= b;
				if (st_ff == ST_FEAT) begin
					cnt_ff <= cnt_ff - 3'h1;
					if (cnt_ff == 3'h1)
						st_ff <= ST_IDLE;
				end
			end
		end
	end
	// Byte is loaded on the strobe rise and held through its fall
	wire rd_take = rise & rd_pat & rdmode_ff;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dq_ff <= 8'h00;
			oe_ff <= 1'b0;
			dqs_ff <= 1'b0;
			id_rd_o <= 1'b0;
		end else begin
			id_rd_o <= rd_take;
			if (rd_take) begin
				dq_ff <= id_byte_i;
				oe_ff <= 1'b1;
				dqs_ff <= 1'b1;
			end else if (fall)
				dqs_ff <= 1'b0;
			if (!rd_pat)
				oe_ff <= 1'b0;
		end
	end
	assign lnk.dq_d = dq_ff;
	assign lnk.dq_d_oe = oe_ff;
	assign lnk.dqs = dqs_ff;
endmodule

// File: rtl/ndc_host.sv
// NAND host end: turns byte requests into link cycles
`include "ndc_map.svh"
module ndc_host import ndc_pkg::*; #(
	parameter int HALF = `NDC_LINK_HALF
) (
	input wire logic clk_i, // System clock
	input wire logic nrst_i, // Async reset, active low
	ndc_link_if.host lnk, // Link to target
	input wire logic req_valid_i, // Request present
	input wire ndc_req_e req_kind_i, // Cycle type
	input wire logic [7:0] req_byte_i, // Command, address or data
	output logic req_ready_o, // Request taken when high
	output logic rsp_valid_o, // Pulse: read byte ready
	output logic [7:0] rsp_byte_o, // Read byte
	output logic busy_o // Target busy, synchronised
);
	// ************************************
	// Link timing
	// ************************************
	localparam logic [7:0] T_RISE = 8'(2 * HALF);
	localparam logic [7:0] T_FALL = 8'(3 * HALF);
	// Long tail covers the target's sampling and answer latency
	localparam logic [7:0] T_DONE = 8'(5 * HALF - 1);
	logic act_ff, rd_ff, lclk_ff, ce_n_ff, cle_ff, ale_ff, wen_ff, oe_ff;
	logic [7:0] cnt_ff, dq_ff;
	logic [8:0] s1_ff, s2_ff, s3_ff, lvl_ff;
	wire [8:0] nxt_lvl = (s2_ff & s3_ff) | (lvl_ff & (s2_ff ^ s3_ff));
	wire take = req_valid_i & ~act_ff;
	wire done = act_ff & (cnt_ff == T_DONE);
	assign req_ready_o = ~act_ff;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_ff <= 9'h100;
			s2_ff <= 9'h100;
			s3_ff <= 9'h100;
			lvl_ff <= 9'h100;
		end else begin
			s1_ff <= {lnk.rb_n, lnk.dq};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			lvl_ff <= nxt_lvl;
		end
	end

	// ************************************
	// Cycle sequencer
	// ************************************
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			act_ff <= 1'b0;
			rd_ff <= 1'b0;
			cnt_ff <= 8'h00;
			lclk_ff <= 1'b0;
			ce_n_ff <= 1'b1;
			cle_ff <= 1'b0;
			ale_ff <= 1'b0;
			wen_ff <= 1'b1;
			oe_ff <= 1'b0;
			dq_ff <= 8'h00;
			rsp_valid_o <= 1'b0;
			rsp_byte_o <= 8'h00;
		end else begin
			rsp_valid_o <= 1'b0;
			if (take) begin
				act_ff <= 1'b1;
				cnt_ff <= 8'h00;
				ce_n_ff <= 1'b0;
				rd_ff <= (req_kind_i == REQ_RD);
				cle_ff <= (req_kind_i == REQ_CMD) | (req_kind_i == REQ_RD);
				ale_ff <= (req_kind_i == REQ_ADDR) | (req_kind_i == REQ_RD);
				wen_ff <= (req_kind_i != REQ_RD);
				oe_ff <= (req_kind_i != REQ_RD);
				// Byte set up a full link period before the rise, held
				dq_ff <= req_byte_i;
			end else if (act_ff) begin
				cnt_ff <= cnt_ff + 8'h01;
				if (cnt_ff == T_RISE - 8'h01)
					lclk_ff <= 1'b1;
				if (cnt_ff == T_FALL - 8'h01)
					lclk_ff <= 1'b0;
				if (done) begin
					act_ff <= 1'b0;
					oe_ff <= 1'b0;
					// Leave the read pattern so the target lets go of dq
					cle_ff <= 1'b0;
					ale_ff <= 1'b0;
					wen_ff <= 1'b1;
					rsp_valid_o <= rd_ff;
					if (rd_ff)
						rsp_byte_o <= nxt_lvl[7:0];
				end
			end
		end
	end
	assign lnk.lclk = lclk_ff;
	assign lnk.ce_n = ce_n_ff;
	assign lnk.cle = cle_ff;
	assign lnk.ale = ale_ff;
	assign lnk.wen = wen_ff;
	assign lnk.dq_h = dq_ff;
	assign lnk.dq_h_oe = oe_ff;
	assign busy_o = ~lvl_ff[8];
endmodule

// File: rtl/ndc_link_if.sv
// Link between NAND host controller and NAND target
interface ndc_link_if;
	logic lclk;
	logic ce_n;
	logic cle;
	logic ale;
	logic wen;
	logic [7:0] dq_h;
	logic dq_h_oe;
	logic [7:0] dq_d;
	logic dq_d_oe;
	logic dqs;
	logic rb_n;
	wire [7:0] dq;
	// Target drive wins; an undriven bus reads as zero
	assign dq = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : 8'h00);
	modport device(input lclk, ce_n, cle, ale, wen, dq,
		output dq_d, dq_d_oe, dqs, rb_n);
	modport host(output lclk, ce_n, cle, ale, wen, dq_h, dq_h_oe,
		input dq, rb_n);
endinterface

// File: rtl/ndc_map.svh
// Command codes, cycle counts and timing for the NAND command decoder
`ifndef NDC_MAP_SVH
`define NDC_MAP_SVH
`define NDC_CMD_READ 8'h00
`define NDC_CMD_RD_CONF 8'h30
`define NDC_CMD_RD_CACHE 8'h31
`define NDC_CMD_RD_MP 8'h32
`define NDC_CMD_CB_RD 8'h35
`define NDC_CMD_RD_END 8'h3f
`define NDC_CMD_PROG 8'h80
`define NDC_CMD_PROG_ALT 8'h81
`define NDC_CMD_CB_PROG 8'h85
`define NDC_CMD_PG_CONF 8'h10
`define NDC_CMD_PG_MP 8'h11
`define NDC_CMD_PG_CACHE 8'h15
`define NDC_CMD_ERASE 8'h60
`define NDC_CMD_ER_CONF 8'hd0
`define NDC_CMD_ER_MP 8'hd1
`define NDC_CMD_ID 8'h90
`define NDC_CMD_GET_FEAT 8'hee
`define NDC_CMD_SET_FEAT 8'hef
`define NDC_CMD_RESET 8'hff
`define NDC_ADDR_PAGE 3'h5
`define NDC_ADDR_ROW 3'h3
`define NDC_ADDR_ONE 3'h1
`define NDC_FEAT_BYTES 3'h4
`define NDC_LUN_POS 16
`define NDC_CLK_NS 20
`define NDC_T_ARRAY_NS 2000
`define NDC_T_CACHE_NS 400
`define NDC_T_RST_NS 1000
`define NDC_LINK_HALF 4
`endif

// File: rtl/ndc_pkg.sv
// Types shared by both ends of the NAND command link
package ndc_pkg;
	typedef enum logic [3:0] {
		OP_NONE = 4'h0, OP_RD_PAGE = 4'h1, OP_RD_MP = 4'h2,
		OP_RD_CACHE_SEQ = 4'h3, OP_RD_CACHE_RND = 4'h4,
		OP_RD_CACHE_END = 4'h5, OP_PROG = 4'h6, OP_PROG_MP = 4'h7,
		OP_PROG_CACHE = 4'h8, OP_ERASE = 4'h9, OP_ERASE_MP = 4'ha,
		OP_ERASE_2P = 4'hb, OP_CB_READ = 4'hc, OP_CB_PROG = 4'hd,
		OP_CB_PROG_MP = 4'he, OP_RESET = 4'hf
	} ndc_op_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_RCONF = 3'h2, ST_DATA = 3'h3,
		ST_ECONF = 3'h4, ST_FEAT = 3'h5
	} ndc_st_e;
	typedef enum logic [1:0] {
		CLS_OTHER = 2'h0, CLS_READ = 2'h1, CLS_CPROG = 2'h2
	} ndc_cls_e;
	typedef enum logic [1:0] {
		REQ_CMD = 2'h0, REQ_ADDR = 2'h1, REQ_WR = 2'h2, REQ_RD = 2'h3
	} ndc_req_e;
endpackage

// File: tb/nand_array_command_decoder_tb.sv
// Bench joining host and target ends of the NAND command link
module nand_array_command_decoder_tb import ndc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic req_valid_i = 1'b0;
	ndc_req_e req_kind_i = REQ_CMD;
	logic [7:0] req_byte_i = 8'h00;
	logic [7:0] id_byte_i = 8'h00;
	logic req_ready_o, rsp_valid_o, busy_o, op_valid_o, op_reject_o;
	logic data_valid_o, id_rd_o;
	int nid = 0;
	logic [7:0] rsp_byte_o, data_o, got_data;
	ndc_op_e op_kind_o;
	ndc_op_e got_kind = OP_NONE;
	logic [0:0] op_lun_o, got_lun;
	logic [23:0] op_row_o, got_row;
	logic [1:0] lun_rdy_o, lun_array_ready_bit_o;
	int err_total = 0;
	int checks = 0;
	int ev = 0;
	int ev0 = 0;
	int nd = 0;
	always #10 clk_i = ~clk_i;
	ndc_link_if lnk();
	ndc_host ndc_host_i (.clk_i(clk_i), .nrst_i(nrst_i), .lnk(lnk.host),
		.req_valid_i(req_valid_i), .req_kind_i(req_kind_i),
		.req_byte_i(req_byte_i), .req_ready_o(req_ready_o),
		.rsp_valid_o(rsp_valid_o), .rsp_byte_o(rsp_byte_o), .busy_o(busy_o));
	// Long array time so cache commands meet a busy array
	ndc_dev #(.T_ARR(16'd400)) ndc_dev_i (.clk_i(clk_i), .nrst_i(nrst_i),
		.lnk(lnk.device), .id_byte_i(id_byte_i), .id_rd_o(id_rd_o),
		.op_valid_o(op_valid_o), .op_kind_o(op_kind_o), .op_lun_o(op_lun_o),
		.op_row_o(op_row_o), .op_reject_o(op_reject_o),
		.data_valid_o(data_valid_o), .data_o(data_o),
		.lun_rdy_o(lun_rdy_o), .lun_array_ready_bit_o(lun_array_ready_bit_o));
	ndc_assertions ndc_assertions_i (.clk_i(clk_i), .nrst_i(nrst_i),
		.lclk(lnk.lclk), .ce_n(lnk.ce_n), .cle(lnk.cle), .ale(lnk.ale),
		.wen(lnk.wen), .dq_h(lnk.dq_h), .dq_h_oe(lnk.dq_h_oe),
		.dq_d(lnk.dq_d), .dq_d_oe(lnk.dq_d_oe), .dqs(lnk.dqs),
		.rb_n(lnk.rb_n), .dq(lnk.dq));
	// ********
	// Monitor and helpers
	// ********
	always @(negedge clk_i) begin
		if (op_valid_o === 1'b1) begin
			got_kind = op_kind_o;
			got_lun = op_lun_o;
			got_row = op_row_o;
			ev++;
		end
		if (op_reject_o === 1'b1) begin
			got_kind = OP_NONE;
			ev++;
		end
		if (id_rd_o === 1'b1)
			nid++;
		if (data_valid_o === 1'b1) begin
			nd++;
			got_data = data_o;
		end
	end
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic req(input ndc_req_e k, input logic [7:0] b);
		int n;
		n = 0;
		@(negedge clk_i);
		while (req_ready_o !== 1'b1 && n < 100) begin
			@(negedge clk_i);
			n++;
		end
		check("ready", n < 100, 1'b1);
		req_valid_i = 1'b1;
		req_kind_i = k;
		req_byte_i = b;
		@(negedge clk_i);
		req_valid_i = 1'b0;
	endtask
	task automatic cmd(input logic [7:0] b);
		req(REQ_CMD, b);
	endtask
	// Row byte carries the LUN in bit 0
	task automatic seq(input logic [7:0] c, input int na,
		input logic [7:0] r, input int ndat);
		logic [7:0] b;
		req(REQ_CMD, c);
		for (int i = 0; i < na; i++) begin
			b = (na == 1 || i == na - 3) ? r : (i == na - 2) ? 8'h12 :
				(i == na - 1) ? 8'h34 : 8'h00;
			req(REQ_ADDR, b);
		end
		for (int i = 0; i < ndat; i++)
			req(REQ_WR, 8'h40 + 8'(i));
	endtask
	task automatic wait_lun(input logic [1:0] rm, input logic [1:0] am);
		int n;
		n = 0;
		while (((lun_rdy_o & rm) !== rm || (lun_array_ready_bit_o & am) !== am)
			&& n < 1000) begin
			@(negedge clk_i);
			n++;
		end
		check("lun wait", n < 1000, 1'b1);
		ev0 = ev;
	endtask
	task automatic wait_ev();
		int n;
		n = 0;
		while (ev == ev0 && n < 80) begin
			@(negedge clk_i);
			n++;
		end
		check("op event", n < 80, 1'b1);
		ev0 = ev;
	endtask
	task automatic expect_op(input ndc_op_e k, input logic l);
		wait_ev();
		check("op kind", got_kind, k);
		if (k != OP_NONE && k != OP_RESET)
			check("op lun", got_lun, l);
	endtask
	task automatic rd(input logic [7:0] b);
		int n;
		n = 0;
		id_byte_i = b;
		req(REQ_RD, 8'h00);
		while (rsp_valid_o !== 1'b1 && n < 60) begin
			@(negedge clk_i);
			n++;
		end
		check("id byte", rsp_byte_o, b);
	endtask
	// ********
	// Scenarios
	// ********
	task automatic t_cache_read();
		wait_lun(2'b01, 2'b01);
		seq(8'h00, 5, 8'h02, 0);
		cmd(8'h30);
		expect_op(OP_RD_PAGE, 1'b0);
		check("row", got_row, 24'h021234);
		wait_lun(2'b01, 2'b00);
		cmd(8'h31);
		expect_op(OP_RD_CACHE_SEQ, 1'b0);
		wait_lun(2'b01, 2'b00);
		check("array_ready_bit", lun_array_ready_bit_o[0], 1'b0);
		seq(8'h00, 5, 8'h02, 0);
		cmd(8'h31);
		expect_op(OP_RD_CACHE_RND, 1'b0);
		wait_lun(2'b01, 2'b00);
		seq(8'h80, 5, 8'h02, 1);
		cmd(8'h15);
		expect_op(OP_NONE, 1'b0);
		seq(8'h00, 5, 8'h02, 0);
		cmd(8'h32);
		expect_op(OP_RD_MP, 1'b0);
		wait_lun(2'b01, 2'b00);
		cmd(8'h3f);
		expect_op(OP_RD_CACHE_END, 1'b0);
	endtask
	task automatic t_cache_prog();
		int n0;
		wait_lun(2'b10, 2'b10);
		n0 = nd;
		seq(8'h80, 5, 8'h03, 3);
		cmd(8'h15);
		expect_op(OP_PROG_CACHE, 1'b1);
		check("data count", nd - n0, 3);
		check("data", got_data, 8'h42);
		wait_lun(2'b10, 2'b00);
		check("array_ready_bit", lun_array_ready_bit_o[1], 1'b0);
		seq(8'h81, 5, 8'h03, 2);
		cmd(8'h15);
		expect_op(OP_PROG_CACHE, 1'b1);
		wait_lun(2'b10, 2'b00);
		cmd(8'h31);
		expect_op(OP_NONE, 1'b0);
	endtask
	// Alternate LUNs so the other one is usually still busy
	task automatic t_table();
		ndc_op_e ks[7] = '{OP_PROG, OP_PROG_MP, OP_ERASE, OP_ERASE_MP,
			OP_CB_READ, OP_CB_PROG, OP_CB_PROG_MP};
		logic [7:0] c1[7] = '{8'h80, 8'h81, 8'h60, 8'h60, 8'h00, 8'h85, 8'h85};
		logic [7:0] c2[7] = '{8'h10, 8'h11, 8'hd0, 8'hd1, 8'h35, 8'h10, 8'h11};
		logic l;
		for (int i = 0; i < 7; i++) begin
			l = i[0];
			wait_lun(2'b01 << l, 2'b01 << l);
			seq(c1[i], c1[i] == 8'h60 ? 3 : 5, {7'h01, l}, int'(c1[i][7]));
			cmd(c2[i]);
			expect_op(ks[i], l);
		end
		wait_lun(2'b01, 2'b01);
		seq(8'h60, 3, 8'h02, 0);
		seq(8'h60, 3, 8'h02, 0);
		cmd(8'hd0);
		expect_op(OP_ERASE_2P, 1'b0);
		seq(8'h60, 3, 8'h02, 0);
		cmd(8'hd0);
		expect_op(OP_NONE, 1'b0);
		cmd(8'h77);
		expect_op(OP_NONE, 1'b0);
	endtask
	task automatic t_row();
		wait_lun(2'b01, 2'b01);
		seq(8'h80, 5, 8'h02, 1);
		seq(8'h85, 5, 8'h02, 1);
		cmd(8'h10);
		wait_ev();
		check("row change", got_kind, OP_PROG);
	endtask
	task automatic t_id_feat();
		int n;
		int n0;
		wait_lun(2'b11, 2'b11);
		seq(8'h90, 1, 8'h00, 0);
		rd(8'h5a);
		rd(8'hc3);
		check("id reads", nid, 2);
		n0 = nd;
		n = 0;
		seq(8'hef, 1, 8'h01, 4);
		while (nd != n0 + 4 && n < 60) begin
			@(negedge clk_i);
			n++;
		end
		check("feature count", nd - n0, 4);
		check("feature data", got_data, 8'h43);
	endtask
	task automatic t_reset();
		int n;
		n = 0;
		wait_lun(2'b11, 2'b11);
		seq(8'h60, 3, 8'h03, 0);
		cmd(8'hd0);
		expect_op(OP_ERASE, 1'b1);
		cmd(8'hff);
		expect_op(OP_RESET, 1'b0);
		while (busy_o !== 1'b1 && n < 20) begin
			@(negedge clk_i);
			n++;
		end
		check("busy", busy_o, 1'b1);
		check("all busy", lun_rdy_o, 2'b00);
		wait_lun(2'b11, 2'b11);
		seq(8'h80, 5, 8'h02, 1);
		cmd(8'hff);
		expect_op(OP_RESET, 1'b0);
		wait_lun(2'b11, 2'b11);
		cmd(8'h10);
		expect_op(OP_NONE, 1'b0);
	endtask
	initial begin
		repeat (16) @(negedge clk_i);
		nrst_i = 1'b1;
		t_cache_read();
		t_cache_prog();
		t_table();
		t_row();
		t_id_feat();
		t_reset();
		print_verdict();
	end
	// Run needs some 6k cycles; generous margin
	initial begin
		#1000000;
		err_total++;
		print_verdict();
	end
endmodule

// File: tb/ndc_assertions.sv
// Link checker for the NAND command decoder pair
module ndc_assertions (
	input wire logic clk_i, // Clock
	input wire logic nrst_i, // Reset
	input wire logic lclk, // Link clock
	input wire logic ce_n, // Enable
	input wire logic cle, // Cmd latch
	input wire logic ale, // Addr latch
	input wire logic wen, // Write cycle
	input wire logic [7:0] dq_h, // Host byte
	input wire logic dq_h_oe, // Host drives
	input wire logic [7:0] dq_d, // Target byte
	input wire logic dq_d_oe, // Target drives
	input wire logic dqs, // Strobe
	input wire logic rb_n, // Ready
	input wire logic [7:0] dq // Wire
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	// ********
	// Target read side and reset busy response
	// ********
	property p_dqs_high;
		dqs && $past(dqs) |-> $stable(dq_d);
	endproperty
	a_dqs_high: assert property (p_dqs_high)
		else $error("read byte moved while strobe high");
	property p_dqs_fall;
		$fell(dqs) |-> $stable(dq_d);
	endproperty
	a_dqs_fall: assert property (p_dqs_fall)
		else $error("read byte moved at strobe fall");
	property p_dqs_oe;
		dqs |-> dq_d_oe;
	endproperty
	a_dqs_oe: assert property (p_dqs_oe)
		else $error("strobe without target drive");
	property p_oe_read;
		$rose(dq_d_oe) |-> cle && ale && !wen && !ce_n;
	endproperty
	a_oe_read: assert property (p_oe_read)
		else $error("target drove outside a read cycle");
	property p_reset_busy;
		$rose(lclk) && cle && !ale && wen && dq == 8'hff |-> ##[1:12] !rb_n;
	endproperty
	a_reset_busy: assert property (p_reset_busy)
		else $error("reset command left target ready");
	// ********
	// Host write side
	// ********
	property p_lclk_high;
		$rose(lclk) |-> lclk [*4] ##1 !lclk;
	endproperty
	a_lclk_high: assert property (p_lclk_high)
		else $error("link clock high time wrong");
	property p_wr_hold;
		$rose(lclk) && dq_h_oe |-> $stable(dq_h) [*5];
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("host byte changed across strobe edges");
	property p_ctl_hold;
		$rose(lclk) |-> ($stable({cle, ale, wen}) && !ce_n) [*5];
	endproperty
	a_ctl_hold: assert property (p_ctl_hold)
		else $error("cycle type changed inside a link cycle");
	property p_cmd_oe;
		$rose(lclk) && wen |-> dq_h_oe;
	endproperty
	a_cmd_oe: assert property (p_cmd_oe)
		else $error("write cycle without host drive");
endmodule
